//--- hw/hmp_pkg.sv
// Purpose: constants shared by both ends of the host memory port.
// Assumes: one 125 MHz clock per end, strobes asynchronous between ends.
// Notes: rules follow.
// What this block does
// - host cannot write memory-mapped control registers
// - one processor cycle stolen per word
// - host waits for acknowledge before starting
// - host rechecks acknowledge before next operation
// - bit 15 set latches overlay block
// - bit 15 clear latches address and space
// - 16-bit bus carries 24-bit program words
// - strobes accepted asynchronously, only while the transfer sequencer is idle
// - address increments after every completed word
// - address latched on latch strobe falling edge
// - one sync cycle then one access cycle
// - host cannot read back target address
// - registers visible at 0x3FE0 and 0x3FE7
// - processor may load target address register
// - straps C=1 B=0 A=1 boot via port
// - execution held until program word 0 written
package hmp_pkg;
    // processor-side data memory map
    localparam logic [13:0] TARGET_ADDR_OFS  = 14'h3FE0;
    localparam logic [13:0] OVERLAY_OFS      = 14'h3FE7;
    localparam logic [13:0] CTRL_REGION_BASE = 14'h3FE0;
    // fields of a latch cycle and of the target register
    localparam int          SEL_OVERLAY_BIT  = 15;
    localparam int          SPACE_BIT        = 14;
    localparam logic        SPACE_PM         = 1'b0;
    localparam logic        SPACE_DM         = 1'b1;
    localparam logic [15:0] TARGET_RESET     = 16'h0000;
    localparam logic [7:0]  OVERLAY_RESET    = 8'h00;
    // strap code that selects boot through the port (C,B,A)
    localparam logic [2:0]  BOOT_HOST_PORT   = 3'b101;
    localparam logic [1:0]  STRAP_SETTLE     = 2'h2;
    // host controller APB map
    localparam logic [7:0]  H_CTRL_OFS       = 8'h00;
    localparam logic [7:0]  H_WDATA_OFS      = 8'h04;
    localparam logic [7:0]  H_RDATA_OFS      = 8'h08;
    localparam logic [7:0]  H_STATUS_OFS     = 8'h0C;
    // host operation codes in control bits 1:0
    localparam logic [1:0]  OP_LATCH         = 2'h0;
    localparam logic [1:0]  OP_WRITE         = 2'h1;
    localparam logic [1:0]  OP_READ          = 2'h2;
    // host pin timing in clock cycles
    localparam logic [3:0]  LATCH_HOLD       = 4'h3;
    localparam logic [3:0]  LATCH_TAIL       = 4'h3;

    typedef enum logic [1:0] {
        DV_IDLE    = 2'b00,
        DV_ACCESS  = 2'b01,
        DV_CAPTURE = 2'b10,
        DV_RELEASE = 2'b11
    } hmp_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE   = 3'b000,
        HS_READY  = 3'b001,
        HS_LATCH  = 3'b010,
        HS_TAIL   = 3'b011,
        HS_STROBE = 3'b100,
        HS_DONE   = 3'b101
    } hmp_host_state_t;
endpackage : hmp_pkg

//--- hw/hmp_if.sv
// Purpose: pins between the external host and the host memory port.
// Assumes: no tristate in design code; the bus level is resolved here.
// Notes: an undriven bus reads as zero.
`timescale 1ns/100ps
interface hmp_if;
    logic        port_select_n;
    logic        address_latch_strobe;
    logic        port_read_strobe_n;
    logic        port_write_strobe_n;
    logic        transfer_acknowledge;
    logic [15:0] host_bus_out;
    logic        host_bus_oe;
    logic [15:0] dev_bus_out;
    logic        dev_bus_oe;
    logic [15:0] multiplexed_addr_data_bus;

    // host drive wins so a contention shows as host data
    assign multiplexed_addr_data_bus = host_bus_oe ? host_bus_out :
                                       dev_bus_oe  ? dev_bus_out  : 16'h0000;

    modport dev (
        input  port_select_n, address_latch_strobe, port_read_strobe_n,
        input  port_write_strobe_n, multiplexed_addr_data_bus,
        output transfer_acknowledge, dev_bus_out, dev_bus_oe
    );
    modport hst (
        output port_select_n, address_latch_strobe, port_read_strobe_n,
        output port_write_strobe_n, host_bus_out, host_bus_oe,
        input  transfer_acknowledge, multiplexed_addr_data_bus
    );
endinterface : hmp_if

//--- hw/hmp_device.sv
// Purpose: device end of the host memory port, moves words to on-chip memory.
// Assumes: memory read data valid the cycle after mem_req.
// Notes: program words travel as two bus words, upper 16 bits first.
`timescale 1ns/100ps
module hmp_device (
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    // boot straps, C B A
    input  wire logic [2:0]  boot_mode,
    output logic             core_run,
    // processor access to the port registers
    input  wire logic        proc_reg_wr,
    input  wire logic [13:0] proc_reg_addr,
    input  wire logic [15:0] proc_reg_wdata,
    output logic [15:0]      proc_reg_rdata,
    // on-chip memory, one cycle stolen per mem_req
    output logic             mem_req,
    output logic             mem_we,
    output logic             mem_dm,
    output logic [13:0]      mem_addr,
    output logic [7:0]       mem_overlay,
    output logic [23:0]      mem_wdata,
    input  wire logic [23:0] mem_rdata,
    // host pins
    hmp_if.dev               hp
);
    // sync chain: {sel_n, al, rd_n, wr_n, bus}
    logic [19:0] pin_s1_reg;
    logic [19:0] pin_s2_reg;
    logic [19:0] pin_s3_reg;
    logic [2:0]  strap_s1_reg;
    logic [2:0]  strap_s2_reg;
    logic [1:0]  strap_cnt_reg;
    logic        strap_done_reg;
    logic        host_boot_reg;
    logic        pm0_written_reg;
    logic [15:0] target_reg;
    logic [7:0]  overlay_reg;
    logic        pm_half_reg;
    logic [15:0] upper_reg;
    logic [7:0]  low_byte_reg;
    logic        op_wr_reg;
    logic        need_mem_reg;
    logic        ctrl_hit_reg;
    logic [23:0] wdata_reg;
    logic [15:0] dout_reg;
    logic        oe_reg;
    logic [15:0] proc_rdata_reg;
    hmp_pkg::hmp_dev_state_t state_reg;

    logic        sel_s2, al_s2, al_s3, rd_act_s2, rd_act_s3;
    logic        wr_act_s2, wr_act_s3, latch_fall, rd_start, wr_start;
    logic        is_pm, ctrl_region;
    logic [15:0] bus_s2, bus_s3;

    // strobes have no relation to clk, so all pins pass three flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 20'hB0000;
            pin_s2_reg <= 20'hB0000;
            pin_s3_reg <= 20'hB0000;
        end else begin
            pin_s1_reg <= {hp.port_select_n, hp.address_latch_strobe,
                           hp.port_read_strobe_n, hp.port_write_strobe_n,
                           hp.multiplexed_addr_data_bus};
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
        end
    end

    // edge decode on the second and third stages only
    always_comb begin
        sel_s2      = ~pin_s2_reg[19];
        al_s2       = pin_s2_reg[18];
        al_s3       = pin_s3_reg[18];
        rd_act_s2   = sel_s2 & ~pin_s2_reg[17];
        rd_act_s3   = ~pin_s3_reg[19] & ~pin_s3_reg[17];
        wr_act_s2   = sel_s2 & ~pin_s2_reg[16];
        wr_act_s3   = ~pin_s3_reg[19] & ~pin_s3_reg[16];
        bus_s2      = pin_s2_reg[15:0];
        bus_s3      = pin_s3_reg[15:0];
        latch_fall  = al_s3 & ~al_s2 & ~pin_s3_reg[19];
        rd_start    = rd_act_s2 & ~rd_act_s3;
        wr_start    = wr_act_s2 & ~wr_act_s3;
        is_pm       = target_reg[hmp_pkg::SPACE_BIT] == hmp_pkg::SPACE_PM;
        ctrl_region = ~is_pm &&
                      target_reg[13:0] >= hmp_pkg::CTRL_REGION_BASE;
    end

    // straps pass two flops and are caught once after reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_s1_reg   <= 3'h0;
            strap_s2_reg   <= 3'h0;
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
            host_boot_reg  <= 1'b0;
        end else begin
            strap_s1_reg <= boot_mode;
            strap_s2_reg <= strap_s1_reg;
            if (!strap_done_reg) begin
                strap_cnt_reg <= strap_cnt_reg + 2'h1;
                if (strap_cnt_reg == hmp_pkg::STRAP_SETTLE) begin
                    strap_done_reg <= 1'b1;
                    host_boot_reg  <= strap_s2_reg ==
                                      hmp_pkg::BOOT_HOST_PORT;
                end
            end
        end
    end

    // boot hold-off released by a write of program word 0
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pm0_written_reg <= 1'b0;
        end else if (mem_req && mem_we && !mem_dm && mem_addr == 14'h0000) begin
            pm0_written_reg <= 1'b1;
        end
    end

    // processor cannot run before straps are known
    assign core_run = strap_done_reg & (~host_boot_reg | pm0_written_reg);

    // target address and overlay: processor write wins over host latch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_reg  <= hmp_pkg::TARGET_RESET;
            overlay_reg <= hmp_pkg::OVERLAY_RESET;
            pm_half_reg <= 1'b0;
        end else if (proc_reg_wr && proc_reg_addr == hmp_pkg::TARGET_ADDR_OFS)
        begin
            target_reg  <= {1'b0, proc_reg_wdata[14:0]};
            pm_half_reg <= 1'b0;
        end else if (proc_reg_wr && proc_reg_addr == hmp_pkg::OVERLAY_OFS)
        begin
            overlay_reg <= proc_reg_wdata[7:0];
        end else if (latch_fall && state_reg == hmp_pkg::DV_IDLE) begin
            if (bus_s3[hmp_pkg::SEL_OVERLAY_BIT]) begin
                overlay_reg <= bus_s3[7:0];
            end else begin
                target_reg  <= {1'b0, bus_s3[14:0]};
                pm_half_reg <= 1'b0;
            end
        end else if (state_reg == hmp_pkg::DV_CAPTURE) begin
            if (is_pm && !pm_half_reg) begin
                pm_half_reg <= 1'b1;
            end else begin
                pm_half_reg      <= 1'b0;
                target_reg[13:0] <= target_reg[13:0] + 14'h0001;
            end
        end
    end

    // processor read port, registered; reads one cycle after address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            proc_rdata_reg <= 16'h0000;
        end else if (proc_reg_addr == hmp_pkg::TARGET_ADDR_OFS) begin
            proc_rdata_reg <= target_reg;
        end else if (proc_reg_addr == hmp_pkg::OVERLAY_OFS) begin
            proc_rdata_reg <= {8'h00, overlay_reg};
        end else begin
            proc_rdata_reg <= 16'h0000;
        end
    end
    assign proc_reg_rdata = proc_rdata_reg;

    // transfer sequencer: sync cycle, access cycle, capture, release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= hmp_pkg::DV_IDLE;
        end else begin
            unique case (state_reg)
                hmp_pkg::DV_IDLE: begin
                    if (rd_start || wr_start) begin
                        state_reg <= hmp_pkg::DV_ACCESS;
                    end
                end
                hmp_pkg::DV_ACCESS:  state_reg <= hmp_pkg::DV_CAPTURE;
                hmp_pkg::DV_CAPTURE: state_reg <= hmp_pkg::DV_RELEASE;
                hmp_pkg::DV_RELEASE: begin
                    if (!rd_act_s2 && !wr_act_s2) begin
                        state_reg <= hmp_pkg::DV_IDLE;
                    end
                end
            endcase
        end
    end

    // request decode at accept; first pm write half only parks in upper_reg
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            op_wr_reg    <= 1'b0;
            need_mem_reg <= 1'b0;
            ctrl_hit_reg <= 1'b0;
            wdata_reg    <= 24'h000000;
            upper_reg    <= 16'h0000;
        end else if (state_reg == hmp_pkg::DV_IDLE &&
                     (rd_start || wr_start)) begin
            op_wr_reg    <= wr_start;
            ctrl_hit_reg <= ctrl_region;
            if (wr_start) begin
                need_mem_reg <= !(is_pm && !pm_half_reg) && !ctrl_region;
                if (is_pm && !pm_half_reg) begin
                    upper_reg <= bus_s2;
                end
                wdata_reg <= is_pm ? {upper_reg, bus_s2[7:0]}
                                   : {8'h00, bus_s2};
            end else begin
                need_mem_reg <= !(is_pm && pm_half_reg) && !ctrl_region;
            end
        end
    end

    // one memory cycle per word, taken from the processor
    assign mem_req     = state_reg == hmp_pkg::DV_ACCESS && need_mem_reg;
    assign mem_we      = op_wr_reg;
    assign mem_dm      = target_reg[hmp_pkg::SPACE_BIT];
    assign mem_addr    = target_reg[13:0];
    assign mem_overlay = overlay_reg;
    assign mem_wdata   = wdata_reg;

    // read data and bus drive; held until the host drops its strobe
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_reg     <= 16'h0000;
            low_byte_reg <= 8'h00;
            oe_reg       <= 1'b0;
        end else if (state_reg == hmp_pkg::DV_CAPTURE && !op_wr_reg) begin
            oe_reg <= 1'b1;
            if (ctrl_hit_reg) begin
                dout_reg <= 16'h0000;
            end else if (is_pm && !pm_half_reg) begin
                dout_reg     <= mem_rdata[23:8];
                low_byte_reg <= mem_rdata[7:0];
            end else if (is_pm) begin
                dout_reg <= {8'h00, low_byte_reg};
            end else begin
                dout_reg <= mem_rdata[15:0];
            end
        end else if (state_reg == hmp_pkg::DV_RELEASE && !rd_act_s2) begin
            oe_reg <= 1'b0;
        end
    end

    // acknowledge low from accept until the access has been captured
    assign hp.transfer_acknowledge = state_reg == hmp_pkg::DV_IDLE ||
                                     state_reg == hmp_pkg::DV_RELEASE;
    assign hp.dev_bus_out = dout_reg;
    assign hp.dev_bus_oe  = oe_reg;
endmodule : hmp_device

//--- hw/hmp_host.sv
// Purpose: host end, turns APB commands into port strobe sequences.
// Assumes: software writes WDATA before CTRL; one operation at a time.
// Notes: commands written while busy are dropped; poll STATUS bit 0.
`timescale 1ns/100ps
module hmp_host (
    // system
    input  wire logic        clk,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // port pins
    hmp_if.hst               hp
);
    logic [1:0]  ack_sync_reg;
    logic [15:0] bus_s1_reg;
    logic [15:0] bus_s2_reg;
    logic [15:0] wdata_reg;
    logic [15:0] rdata_reg;
    logic [1:0]  op_reg;
    logic        start_reg;
    logic [3:0]  cnt_reg;
    logic        sel_n_reg, al_reg, rd_n_reg, wr_n_reg, oe_reg;
    logic        acc, mapped, ack_s;
    hmp_pkg::hmp_host_state_t state_reg;

    assign acc    = psel & penable;
    assign ack_s  = ack_sync_reg[1];
    assign mapped = paddr == hmp_pkg::H_CTRL_OFS ||
                    paddr == hmp_pkg::H_WDATA_OFS ||
                    paddr == hmp_pkg::H_RDATA_OFS ||
                    paddr == hmp_pkg::H_STATUS_OFS;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // device pins are asynchronous to this clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_sync_reg <= 2'b00;
            bus_s1_reg   <= 16'h0000;
            bus_s2_reg   <= 16'h0000;
        end else begin
            ack_sync_reg <= {ack_sync_reg[0], hp.transfer_acknowledge};
            bus_s1_reg   <= hp.multiplexed_addr_data_bus;
            bus_s2_reg   <= bus_s1_reg;
        end
    end

    // software registers; CTRL write raises a one-cycle start
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdata_reg <= 16'h0000;
            op_reg    <= hmp_pkg::OP_LATCH;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (acc && pwrite && paddr == hmp_pkg::H_WDATA_OFS) begin
                wdata_reg <= pwdata[15:0];
            end
            if (acc && pwrite && paddr == hmp_pkg::H_CTRL_OFS &&
                state_reg == hmp_pkg::HS_IDLE) begin
                op_reg    <= pwdata[1:0];
                start_reg <= 1'b1;
            end
        end
    end

    // read mux; reserved bits read zero
    always_comb begin
        prdata = 32'h00000000;
        if (paddr == hmp_pkg::H_CTRL_OFS) begin
            prdata = {30'h00000000, op_reg};
        end else if (paddr == hmp_pkg::H_WDATA_OFS) begin
            prdata = {16'h0000, wdata_reg};
        end else if (paddr == hmp_pkg::H_RDATA_OFS) begin
            prdata = {16'h0000, rdata_reg};
        end else if (paddr == hmp_pkg::H_STATUS_OFS) begin
            prdata = {30'h00000000, ack_s, state_reg != hmp_pkg::HS_IDLE};
        end
    end

    // pin sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= hmp_pkg::HS_IDLE;
            cnt_reg   <= 4'h0;
            sel_n_reg <= 1'b1;
            al_reg    <= 1'b0;
            rd_n_reg  <= 1'b1;
            wr_n_reg  <= 1'b1;
            oe_reg    <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            unique case (state_reg)
                hmp_pkg::HS_IDLE: begin
                    if (start_reg) begin
                        state_reg <= hmp_pkg::HS_READY;
                    end
                end
                hmp_pkg::HS_READY: begin
                    // never start while the device shows busy
                    if (ack_s) begin
                        sel_n_reg <= 1'b0;
                        cnt_reg   <= hmp_pkg::LATCH_HOLD;
                        if (op_reg == hmp_pkg::OP_READ) begin
                            rd_n_reg  <= 1'b0;
                            state_reg <= hmp_pkg::HS_STROBE;
                        end else if (op_reg == hmp_pkg::OP_WRITE) begin
                            wr_n_reg  <= 1'b0;
                            oe_reg    <= 1'b1;
                            state_reg <= hmp_pkg::HS_STROBE;
                        end else begin
                            al_reg    <= 1'b1;
                            oe_reg    <= 1'b1;
                            state_reg <= hmp_pkg::HS_LATCH;
                        end
                    end
                end
                hmp_pkg::HS_LATCH: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0) begin
                        al_reg    <= 1'b0;
                        cnt_reg   <= hmp_pkg::LATCH_TAIL;
                        state_reg <= hmp_pkg::HS_TAIL;
                    end
                end
                hmp_pkg::HS_TAIL: begin
                    cnt_reg <= cnt_reg - 4'h1;
                    if (cnt_reg == 4'h0) begin
                        sel_n_reg <= 1'b1;
                        oe_reg    <= 1'b0;
                        state_reg <= hmp_pkg::HS_IDLE;
                    end
                end
                hmp_pkg::HS_STROBE: begin
                    if (!ack_s) begin
                        state_reg <= hmp_pkg::HS_DONE;
                    end
                end
                hmp_pkg::HS_DONE: begin
                    if (ack_s) begin
                        rdata_reg <= bus_s2_reg;
                        sel_n_reg <= 1'b1;
                        rd_n_reg  <= 1'b1;
                        wr_n_reg  <= 1'b1;
                        oe_reg    <= 1'b0;
                        state_reg <= hmp_pkg::HS_IDLE;
                    end
                end
                default: state_reg <= hmp_pkg::HS_IDLE;
            endcase
        end
    end

    assign hp.port_select_n        = sel_n_reg;
    assign hp.address_latch_strobe = al_reg;
    assign hp.port_read_strobe_n   = rd_n_reg;
    assign hp.port_write_strobe_n  = wr_n_reg;
    assign hp.host_bus_out         = wdata_reg;
    assign hp.host_bus_oe          = oe_reg;
endmodule : hmp_host

//--- tb/hmp_assertions.sv
// Purpose: pin-level checks between the two ends of the host memory port.
// Assumes: one clock domain shared by both ends.
// Notes: sees only the interface signals.
`timescale 1ns/100ps
module hmp_assertions (
    // system
    input wire logic        clk,
    input wire logic        rst_n,
    // host pins
    input wire logic        port_select_n,
    input wire logic        address_latch_strobe,
    input wire logic        port_read_strobe_n,
    input wire logic        port_write_strobe_n,
    input wire logic [15:0] host_bus_out,
    input wire logic        host_bus_oe,
    // device pins
    input wire logic        transfer_acknowledge,
    input wire logic [15:0] dev_bus_out,
    input wire logic        dev_bus_oe,
    input wire logic [15:0] multiplexed_addr_data_bus
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // shorthands for the handshake
    wire ack  = transfer_acknowledge;
    wire strb = !(port_read_strobe_n && port_write_strobe_n);

    a_ack_low_two: assert property ($fell(ack) |=> !ack ##1 ack)
        else $error("ack low span wrong");
    a_ack_after_strobe: assert property ($fell(port_write_strobe_n) |-> ##[2:6] !ack)
        else $error("write strobe not acknowledged in time");
    a_ack_has_cause: assert property ($fell(ack) |-> $past(!port_select_n && strb, 2))
        else $error("ack fell without a strobe");
    a_read_data_out: assert property ($rose(ack) && !port_read_strobe_n |->
        dev_bus_oe && multiplexed_addr_data_bus == dev_bus_out)
        else $error("read data not on bus at ack");
    a_start_on_ack: assert property ($fell(port_read_strobe_n) || $fell(port_write_strobe_n) |-> ack)
        else $error("strobe started while busy");
    a_release_on_ack: assert property ($rose(port_read_strobe_n) || $rose(port_write_strobe_n)
        |-> ack && $past(ack))
        else $error("strobe released before completion");
    a_overlay_zero: assert property ($fell(address_latch_strobe) && host_bus_out[15]
        |-> host_bus_out[14:8] == 7'h00)
        else $error("overlay latch upper bits not zero");
    a_latch_select: assert property ($fell(address_latch_strobe)
        |-> !port_select_n && host_bus_oe && ack)
        else $error("latch without select, bus or ack");
    a_one_strobe: assert property (port_read_strobe_n || port_write_strobe_n)
        else $error("read and write strobes together");
    // main traffic kinds
    c_write: cover property ($fell(port_write_strobe_n));
    c_read: cover property ($fell(port_read_strobe_n));
    c_latch: cover property ($fell(address_latch_strobe));
endmodule : hmp_assertions

//--- tb/hmp_bench.sv
// Purpose: drives the host end over APB and checks words at device memory.
// Assumes: straps select boot through the port.
// Notes: a small array stands in for on-chip RAM.
`timescale 1ns/100ps
module hmp_bench;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic        proc_reg_wr, core_run, mem_req, mem_we, mem_dm;
    logic [7:0]  paddr, mem_overlay;
    logic [31:0] pwdata, prdata, q;
    logic [13:0] proc_reg_addr, mem_addr;
    logic [15:0] proc_reg_wdata, proc_reg_rdata;
    logic [23:0] mem_wdata, mem_rdata;
    logic [23:0] pm [32];
    logic [23:0] dm [32];
    int          n_fail, tests_run;

    hmp_if hp ();
    hmp_device hmp_device_inst (.clk(clk), .rst_n(rst_n),
        .boot_mode(hmp_pkg::BOOT_HOST_PORT), .core_run(core_run),
        .proc_reg_wr(proc_reg_wr), .proc_reg_addr(proc_reg_addr),
        .proc_reg_wdata(proc_reg_wdata), .proc_reg_rdata(proc_reg_rdata),
        .mem_req(mem_req), .mem_we(mem_we), .mem_dm(mem_dm),
        .mem_addr(mem_addr), .mem_overlay(mem_overlay), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .hp(hp));
    hmp_host hmp_host_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hp(hp));
    hmp_assertions hmp_assertions_inst (.clk(clk), .rst_n(rst_n),
        .port_select_n(hp.port_select_n),
        .address_latch_strobe(hp.address_latch_strobe),
        .port_read_strobe_n(hp.port_read_strobe_n),
        .port_write_strobe_n(hp.port_write_strobe_n),
        .host_bus_out(hp.host_bus_out), .host_bus_oe(hp.host_bus_oe),
        .transfer_acknowledge(hp.transfer_acknowledge),
        .dev_bus_out(hp.dev_bus_out), .dev_bus_oe(hp.dev_bus_oe),
        .multiplexed_addr_data_bus(hp.multiplexed_addr_data_bus));

    always #4 clk = ~clk;
    // ram model: read data lands the cycle after the stolen cycle
    always @(posedge clk) begin
        if (mem_req && mem_we && mem_dm) dm[mem_addr[4:0]] <= mem_wdata;
        if (mem_req && mem_we && !mem_dm) pm[mem_addr[4:0]] <= mem_wdata;
        if (mem_req) mem_rdata <= mem_dm ? dm[mem_addr[4:0]] : pm[mem_addr[4:0]];
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; data and error taken at the pready edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // host operation, polled to completion; q holds the read word
    task op(input logic [1:0] c, input logic [15:0] d);
        apb(1'b1, hmp_pkg::H_WDATA_OFS, {16'h0000, d});
        apb(1'b1, hmp_pkg::H_CTRL_OFS, {30'h0, c});
        do apb(1'b0, hmp_pkg::H_STATUS_OFS, 32'h0); while (q[0] !== 1'b0);
        apb(1'b0, hmp_pkg::H_RDATA_OFS, 32'h0);
    endtask : op
    task preg(input logic [13:0] a);
        proc_reg_addr <= a;
        repeat (3) @(posedge clk);
        q = {16'h0000, proc_reg_rdata};
    endtask : preg

    task end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // watchdog, far beyond a normal run
    initial begin
        #400000;
        n_fail++;
        end_of_test;
    end

    initial begin
        {clk, rst_n, psel, penable, pwrite, proc_reg_wr} = 6'h00;
        {paddr, pwdata, proc_reg_addr, proc_reg_wdata} = 70'h0;
        n_fail = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check(32'(core_run), 32'h0);
        op(hmp_pkg::OP_LATCH, 16'h4010);
        op(hmp_pkg::OP_WRITE, 16'hA5A5);
        op(hmp_pkg::OP_WRITE, 16'h5A5A);
        check(32'(dm[16][15:0]), 32'hA5A5);
        check(32'(dm[17][15:0]), 32'h5A5A);
        preg(hmp_pkg::TARGET_ADDR_OFS);
        check(q, 32'h4012);
        op(hmp_pkg::OP_LATCH, 16'h4010);
        op(hmp_pkg::OP_READ, 16'h0000);
        check(q, 32'hA5A5);
        op(hmp_pkg::OP_READ, 16'h0000);
        check(q, 32'h5A5A);
        $display("data stream test done");
        op(hmp_pkg::OP_LATCH, 16'h8003);
        op(hmp_pkg::OP_LATCH, 16'h7FE7);
        op(hmp_pkg::OP_WRITE, 16'h00FF);
        preg(hmp_pkg::OVERLAY_OFS);
        check(q, 32'h0003);
        check(32'(mem_overlay), 32'h3);
        preg(hmp_pkg::TARGET_ADDR_OFS);
        check(q, 32'h7FE8);
        op(hmp_pkg::OP_READ, 16'h0000);
        check(q, 32'h0);
        $display("overlay and control region test done");
        proc_reg_addr  <= hmp_pkg::TARGET_ADDR_OFS;
        proc_reg_wdata <= 16'h4018;
        proc_reg_wr    <= 1'b1;
        @(posedge clk);
        proc_reg_wr    <= 1'b0;
        op(hmp_pkg::OP_WRITE, 16'hC3C3);
        check(32'(dm[24][15:0]), 32'hC3C3);
        $display("processor address load test done");
        op(hmp_pkg::OP_LATCH, 16'h0000);
        op(hmp_pkg::OP_WRITE, 16'h1234);
        op(hmp_pkg::OP_WRITE, 16'h0056);
        check(32'(pm[0]), 32'h123456);
        check(32'(core_run), 32'h1);
        op(hmp_pkg::OP_LATCH, 16'h0000);
        op(hmp_pkg::OP_READ, 16'h0000);
        check(q, 32'h1234);
        op(hmp_pkg::OP_READ, 16'h0000);
        check(q, 32'h0056);
        $display("program word boot test done");
        apb(1'b0, 8'h10, 32'h0);
        check({q[30:0], err}, 32'h1);
        $display("unmapped access test done");
        end_of_test;
    end
endmodule : hmp_bench
